// ---- src/bmw_window_decode.v ----
`timescale 1ns/10ps
`include "bmw_regs.vh"

// Notes on behaviour
// - Memory bottom field bits 15:4 is writable, maps to address 31:20, low bits zero.
// - Memory top field bits 31:20 is writable, maps to address 31:20, low bits ones.
// - Prefetch bottom field bits 15:4 is writable, maps to 31:20, low bits zero.
// - Prefetch top field bits 31:20 is writable, maps to 31:20, low bits ones.
// - Memory window low nibbles 3:0 and 19:16 are read-only zero.
// - Prefetch window low nibbles 3:0 and 19:16 read as one, meaning 64-bit.
// - Memory window bottom and top decide forwarding of memory transactions.
// - Prefetch bottom is upper register, 12-bit field, then twenty zero bits.
// - Prefetch top is upper register, 12-bit field, then twenty one bits.
// - Both windows compare at one-megabyte alignment and granularity only.
// - Prefetch bottom and top decide forwarding of memory reads and writes.
// - Separate writable 32-bit register holds prefetch bottom bits 63:32, reset zero.
module bmw_window_decode (
	input  wire        clk_sys,
	input  wire        sys_rst,
	input  wire        cfg_wr,
	input  wire        cfg_rd,
	input  wire [7:0]  cfg_addr,
	input  wire [3:0]  cfg_byte_en_n,
	input  wire [31:0] cfg_wdata,
	output reg  [31:0] cfg_rdata,
	output reg         cfg_rd_valid,
	input  wire        txn_valid,
	input  wire [63:0] txn_addr,
	output reg         hit_valid,
	output reg         mem_window_hit,
	output reg         prefetch_window_hit,
	output reg         forward_hit,
	output wire [31:0] mem_bottom_addr,
	output wire [31:0] mem_top_addr,
	output wire [63:0] prefetch_bottom_addr,
	output wire [63:0] prefetch_top_addr
);

	reg  [11:0] mem_bottom;
	reg  [11:0] mem_top;
	reg  [11:0] pf_bottom;
	reg  [11:0] pf_top;
	reg  [31:0] pf_bottom_hi;
	reg  [31:0] pf_top_hi;
	reg  [31:0] next_rdata;
	wire [31:0] mem_word;
	wire [31:0] pf_word;
	wire [31:0] mem_new;
	wire [31:0] pf_new;
	wire [31:0] pf_bottom_hi_new;
	wire [31:0] pf_top_hi_new;
	wire        sel_mem;
	wire        sel_pf;
	wire        sel_pf_bottom_hi;
	wire        sel_pf_top_hi;
	wire        addr_upper_zero;

	// Byte-lane merge with active-low byte enables
	function [31:0] merge_bytes;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  be_n;
		integer      i;
		begin
			merge_bytes = old_val;
			for (i = 0; i < 4; i = i + 1) begin
				if (!be_n[i]) begin
					merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
				end
			end
		end
	endfunction

	// Dword offset decode, low two address bits ignored
	function offset_match;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			offset_match = (addr[7:2] == ofs[7:2]);
		end
	endfunction

	// Inclusive range test on megabyte-aligned address bits
	function in_window;
		input [43:0] addr_mb;
		input [43:0] bottom_mb;
		input [43:0] top_mb;
		begin
			in_window = (addr_mb >= bottom_mb) && (addr_mb <= top_mb);
		end
	endfunction

	assign sel_mem          = offset_match(cfg_addr, `BMW_OFS_MEM_WIN);
	assign sel_pf           = offset_match(cfg_addr, `BMW_OFS_PF_WIN);
	assign sel_pf_bottom_hi = offset_match(cfg_addr, `BMW_OFS_PF_BOTTOM_HI);
	assign sel_pf_top_hi    = offset_match(cfg_addr, `BMW_OFS_PF_TOP_HI);

	// Read views of the window words
	assign mem_word = {mem_top, `BMW_MEM_FLAG, mem_bottom, `BMW_MEM_FLAG};
	assign pf_word  = {pf_top, `BMW_PF_FLAG, pf_bottom, `BMW_PF_FLAG};

	assign mem_new          = merge_bytes(mem_word, cfg_wdata, cfg_byte_en_n);
	assign pf_new           = merge_bytes(pf_word, cfg_wdata, cfg_byte_en_n);
	assign pf_bottom_hi_new = merge_bytes(pf_bottom_hi, cfg_wdata, cfg_byte_en_n);
	assign pf_top_hi_new    = merge_bytes(pf_top_hi, cfg_wdata, cfg_byte_en_n);

	// Register writes; read-only nibbles are never stored
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mem_bottom   <= `BMW_FIELD_RST;
			mem_top      <= `BMW_FIELD_RST;
			pf_bottom    <= `BMW_FIELD_RST;
			pf_top       <= `BMW_FIELD_RST;
			pf_bottom_hi <= `BMW_HI_RST;
			pf_top_hi    <= `BMW_HI_RST;
		end else if (cfg_wr) begin
			if (sel_mem) begin
				mem_bottom <= mem_new[`BMW_BOTTOM_MSB:`BMW_BOTTOM_LSB];
				mem_top    <= mem_new[`BMW_TOP_MSB:`BMW_TOP_LSB];
			end
			if (sel_pf) begin
				pf_bottom <= pf_new[`BMW_BOTTOM_MSB:`BMW_BOTTOM_LSB];
				pf_top    <= pf_new[`BMW_TOP_MSB:`BMW_TOP_LSB];
			end
			if (sel_pf_bottom_hi) begin
				pf_bottom_hi <= pf_bottom_hi_new;
			end
			if (sel_pf_top_hi) begin
				pf_top_hi <= pf_top_hi_new;
			end
		end
	end

	// Read multiplexer; unmapped offsets read zero
	always @* begin
		next_rdata = `BMW_RDATA_RST;
		if (sel_mem) begin
			next_rdata = mem_word;
		end else if (sel_pf) begin
			next_rdata = pf_word;
		end else if (sel_pf_bottom_hi) begin
			next_rdata = pf_bottom_hi;
		end else if (sel_pf_top_hi) begin
			next_rdata = pf_top_hi;
		end
	end

	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_rdata    <= `BMW_RDATA_RST;
			cfg_rd_valid <= 1'b0;
		end else begin
			cfg_rd_valid <= cfg_rd;
			if (cfg_rd) begin
				cfg_rdata <= next_rdata;
			end
		end
	end

	// Full window addresses
	assign mem_bottom_addr      = {mem_bottom, `BMW_LOW_ZERO};
	assign mem_top_addr         = {mem_top, `BMW_LOW_ONES};
	assign prefetch_bottom_addr = {pf_bottom_hi, pf_bottom, `BMW_LOW_ZERO};
	assign prefetch_top_addr    = {pf_top_hi, pf_top, `BMW_LOW_ONES};

	// Memory window covers only the low 4 GB
	assign addr_upper_zero = (txn_addr[63:32] == `BMW_UPPER_ZERO);

	// Registered window decode, one cycle after txn_valid
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			hit_valid           <= 1'b0;
			mem_window_hit      <= 1'b0;
			prefetch_window_hit <= 1'b0;
			forward_hit         <= 1'b0;
		end else begin
			hit_valid <= txn_valid;
			if (txn_valid) begin
				// Only address bits 63:20 take part
				mem_window_hit <= addr_upper_zero &&
					in_window(txn_addr[63:`BMW_GRAN_LSB],
						{`BMW_UPPER_ZERO, mem_bottom},
						{`BMW_UPPER_ZERO, mem_top});
				prefetch_window_hit <= in_window(txn_addr[63:`BMW_GRAN_LSB],
					{pf_bottom_hi, pf_bottom},
					{pf_top_hi, pf_top});
				forward_hit <= (addr_upper_zero &&
					in_window(txn_addr[63:`BMW_GRAN_LSB],
						{`BMW_UPPER_ZERO, mem_bottom},
						{`BMW_UPPER_ZERO, mem_top})) ||
					in_window(txn_addr[63:`BMW_GRAN_LSB],
						{pf_bottom_hi, pf_bottom},
						{pf_top_hi, pf_top});
			end else begin
				mem_window_hit      <= 1'b0;
				prefetch_window_hit <= 1'b0;
				forward_hit         <= 1'b0;
			end
		end
	end

endmodule // bmw_window_decode

// ---- shared/bmw_regs.vh ----
`ifndef BMW_REGS_VH
`define BMW_REGS_VH

// Configuration offsets, byte addresses
`define BMW_OFS_MEM_WIN       8'h20
`define BMW_OFS_PF_WIN        8'h24
`define BMW_OFS_PF_BOTTOM_HI  8'h28
`define BMW_OFS_PF_TOP_HI     8'h2C

// Field positions inside the window words
`define BMW_BOTTOM_LSB        4
`define BMW_BOTTOM_MSB        15
`define BMW_TOP_LSB           20
`define BMW_TOP_MSB           31
`define BMW_BOTTOM_FLAG_MSB   3
`define BMW_BOTTOM_FLAG_LSB   0
`define BMW_TOP_FLAG_MSB      19
`define BMW_TOP_FLAG_LSB      16

// Read-only low nibbles
`define BMW_MEM_FLAG          4'h0
`define BMW_PF_FLAG           4'h1

// Reset values of the writable fields and of the read data
`define BMW_FIELD_RST         12'h000
`define BMW_HI_RST            32'h0000_0000
`define BMW_RDATA_RST         32'h0000_0000

// Window granularity: address bits below this are not compared
`define BMW_GRAN_LSB          20
`define BMW_LOW_ZERO          20'h0_0000
`define BMW_LOW_ONES          20'hF_FFFF
`define BMW_UPPER_ZERO        32'h0000_0000

`endif

// ---- sim/bmw_props.sv ----
`timescale 1ns/10ps
module bmw_props (
	input wire        clk_sys,
	input wire        sys_rst,
	input wire        cfg_rd,
	input wire [7:0]  cfg_addr,
	input wire [31:0] cfg_rdata,
	input wire        cfg_rd_valid,
	input wire        txn_valid,
	input wire [63:0] txn_addr,
	input wire        hit_valid,
	input wire        mem_window_hit,
	input wire        prefetch_window_hit,
	input wire        forward_hit,
	input wire [31:0] mem_bottom_addr,
	input wire [31:0] mem_top_addr,
	input wire [63:0] prefetch_bottom_addr,
	input wire [63:0] prefetch_top_addr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire m_match = txn_addr[63:32] == 32'h0000_0000 && txn_addr[31:20] >= mem_bottom_addr[31:20]
		&& txn_addr[31:20] <= mem_top_addr[31:20];
	wire p_match = txn_addr[63:20] >= prefetch_bottom_addr[63:20]
		&& txn_addr[63:20] <= prefetch_top_addr[63:20];
	property p_mn; cfg_rd && cfg_addr[7:2] == 6'h08 |=> cfg_rd_valid && cfg_rdata[3:0] == 4'h0
		&& cfg_rdata[19:16] == 4'h0; endproperty
	a_mn: assert property (p_mn) else $error("mem nibble");
	property p_pn; cfg_rd && cfg_addr[7:2] == 6'h09 |=> cfg_rd_valid && cfg_rdata[3:0] == 4'h1
		&& cfg_rdata[19:16] == 4'h1; endproperty
	a_pn: assert property (p_pn) else $error("pf nibble");
	property p_ml; mem_bottom_addr[19:0] == 20'h0_0000 && mem_top_addr[19:0] == 20'hF_FFFF; endproperty
	a_ml: assert property (p_ml) else $error("mem low bits");
	property p_pl; prefetch_bottom_addr[19:0] == 20'h0_0000
		&& prefetch_top_addr[19:0] == 20'hF_FFFF; endproperty
	a_pl: assert property (p_pl) else $error("pf low bits");
	property p_mh; txn_valid |=> mem_window_hit == $past(m_match); endproperty
	a_mh: assert property (p_mh) else $error("mem hit");
	property p_ph; txn_valid |=> prefetch_window_hit == $past(p_match); endproperty
	a_ph: assert property (p_ph) else $error("pf hit");
	property p_fw; txn_valid |=> hit_valid && forward_hit == (mem_window_hit || prefetch_window_hit);
	endproperty
	a_fw: assert property (p_fw) else $error("forward");
	property p_id; !txn_valid |=> !hit_valid && !forward_hit; endproperty
	a_id: assert property (p_id) else $error("idle hit");
endmodule // bmw_props
bind bmw_window_decode bmw_props u_props (.*);

// ---- sim/bmw_cfg_host.sv ----
`timescale 1ns/10ps
module bmw_cfg_host (
	input  wire        clk_sys,
	output reg         cfg_wr,
	output reg         cfg_rd,
	output reg  [7:0]  cfg_addr,
	output reg  [3:0]  cfg_byte_en_n,
	output reg  [31:0] cfg_wdata,
	output reg         txn_valid,
	output reg  [63:0] txn_addr
);
	initial {cfg_wr, cfg_rd, cfg_addr, cfg_byte_en_n, cfg_wdata, txn_valid, txn_addr} = 0;
	task wr(input [7:0] a, input [3:0] be, input [31:0] d);
		@(negedge clk_sys) {cfg_wr, cfg_addr, cfg_byte_en_n, cfg_wdata} = {1'b1, a, be, d};
		@(negedge clk_sys) {cfg_wr, cfg_wdata} = {1'b0, ~d};
	endtask
	task rd(input [7:0] a);
		@(negedge clk_sys) {cfg_rd, cfg_addr} = {1'b1, a};
		@(negedge clk_sys) {cfg_rd, cfg_addr} = {1'b0, ~a};
	endtask
	task tx(input [63:0] a);
		@(negedge clk_sys) {txn_valid, txn_addr} = {1'b1, a};
		@(negedge clk_sys) {txn_valid, txn_addr} = {1'b0, ~a};
	endtask
endmodule // bmw_cfg_host

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	reg         clk_sys = 0;
	reg         sys_rst = 1;
	integer     failures = 0;
	integer     cmp_count = 0;
	wire        cfg_wr, cfg_rd, cfg_rd_valid, txn_valid, hit_valid;
	wire        mem_window_hit, prefetch_window_hit, forward_hit;
	wire [7:0]  cfg_addr;
	wire [3:0]  cfg_byte_en_n;
	wire [31:0] cfg_wdata, cfg_rdata, mem_bottom_addr, mem_top_addr;
	wire [63:0] txn_addr, prefetch_bottom_addr, prefetch_top_addr;
	bmw_window_decode u_dut (.*);
	bmw_cfg_host u_host (.*);
	always #2 clk_sys = ~clk_sys;
	task chk(input string n, input [63:0] e, input [63:0] s);
		cmp_count = cmp_count + 1;
		if (s !== e) begin
			failures = failures + 1;
			$display("CHECK FAILED %0s exp %h got %h", n, e, s);
		end
	endtask
	task rc(input [7:0] a, input [31:0] e);
		u_host.rd(a);
		chk("cfg_rdata", {1'b1, e}, {cfg_rd_valid, cfg_rdata});
	endtask
	task hc(input [63:0] a, input m, input p);
		u_host.tx(a);
		chk("hits", {1'b1, m, p, m | p}, {hit_valid, mem_window_hit, prefetch_window_hit, forward_hit});
	endtask
	task report_and_stop;
		if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys) sys_rst = 0;
		chk("mem_top_addr", 64'h0000_0000_000F_FFFF, mem_top_addr);
		chk("prefetch_top_addr", 64'h0000_0000_000F_FFFF, prefetch_top_addr);
		chk("prefetch_bottom_addr", 64'h0, prefetch_bottom_addr);
		rc(8'h20, 32'h0000_0000);
		rc(8'h24, 32'h0001_0001);
		rc(8'h28, 32'h0000_0000);
		rc(8'h30, 32'h0000_0000);
		u_host.wr(8'h20, 4'h0, 32'hFFFF_FFFF);
		rc(8'h20, 32'hFFF0_FFF0);
		u_host.wr(8'h24, 4'h0, 32'hFFFF_FFFF);
		rc(8'h24, 32'hFFF1_FFF1);
		u_host.wr(8'h20, 4'hC, 32'h0000_0100);
		rc(8'h20, 32'hFFF0_0100);
		// Windows programmed before decode is relied on
		u_host.wr(8'h20, 4'h3, 32'h1230_0000);
		u_host.wr(8'h28, 4'h0, 32'h0000_0001);
		u_host.wr(8'h2C, 4'h0, 32'h0000_0001);
		u_host.wr(8'h24, 4'h0, 32'h2000_0100);
		rc(8'h28, 32'h0000_0001);
		hc(64'h0000_0000_0100_0000, 1, 0);
		hc(64'h0000_0000_00FF_FFFF, 0, 0);
		hc(64'h0000_0000_123F_FFFF, 1, 0);
		hc(64'h0000_0000_1240_0000, 0, 0);
		hc(64'h0000_0001_0100_0000, 0, 1);
		hc(64'h0000_0001_200F_FFFF, 0, 1);
		hc(64'h0000_0001_2010_0000, 0, 0);
		hc(64'h0000_0000_2000_0000, 0, 0);
		chk("mem_bottom_addr", 64'h0000_0000_0100_0000, mem_bottom_addr);
		chk("mem_top_addr", 64'h0000_0000_123F_FFFF, mem_top_addr);
		chk("prefetch_bottom_addr", 64'h0000_0001_0100_0000, prefetch_bottom_addr);
		chk("prefetch_top_addr", 64'h0000_0001_200F_FFFF, prefetch_top_addr);
		rc(8'h2C, 32'h0000_0001);
		// Inverted memory window: top below bottom
		u_host.wr(8'h20, 4'h0, 32'h0100_0200);
		hc(64'h0000_0000_0150_0000, 0, 0);
		hc(64'h0000_0000_0200_0000, 0, 0);
		hc(64'h0000_0000_0100_0000, 0, 0);
		// Reset in mid-run restores reset values
		@(negedge clk_sys) sys_rst = 1;
		@(negedge clk_sys) sys_rst = 0;
		chk("mem_top_addr", 64'h0000_0000_000F_FFFF, mem_top_addr);
		rc(8'h24, 32'h0001_0001);
		rc(8'h28, 32'h0000_0000);
		rc(8'h2C, 32'h0000_0000);
		report_and_stop;
	end
endmodule // testbench
